// ---- verif/bsr_ctrl_model.sv ----
`timescale 1ns/10ps
module bsr_ctrl_model (
  input  wire logic          clk_i,
  output logic               k_o,
  output logic               k_n_o,
  output logic               wr_n_o,
  output logic               rd_n_o,
  output bsr_pkg::bsr_addr_t addr_o,
  output bsr_pkg::bsr_data_t data_o,
  output logic [3:0]         bw_n_o,
  output int                 hcnt_o
);
  import bsr_pkg::*;
  // Set at declaration so a time-zero clock edge cannot leave it unknown
  logic [2:0] ph = 3'h0;
  initial
  begin
    k_o = 1'b0;
    k_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = '0;
    data_o = '0;
    bw_n_o = 4'hF;
    hcnt_o = 0;
  end
  // 160 ns pair, well under the bypass ceiling
  always @(negedge clk_i)
  begin
    ph <= ph + 3'h1;
    if (ph[1:0] == 2'h3)
    begin
      k_o <= ~k_o;
      k_n_o <= k_o;
      hcnt_o <= hcnt_o + 1;
    end
  end
  task automatic wait_ph(input logic [2:0] at);
    @(negedge clk_i);
    while (ph != at)
      @(negedge clk_i);
  endtask
  // Pins settle two bench cycles before each edge and hold two after
  task automatic kcyc(input logic wr_n, input logic rd_n, input logic bogus, input logic dv,
                      input bsr_addr_t a, input bsr_data_t d0, input bsr_data_t d1,
                      input logic [3:0] b0, input logic [3:0] b1, output int kidx);
    wait_ph(3'h1);
    kidx = hcnt_o + 1;
    wr_n_o <= wr_n;
    rd_n_o <= rd_n;
    addr_o <= (wr_n & rd_n) ? ~addr_o : a;
    data_o <= dv ? d0 : ~data_o;
    bw_n_o <= dv ? b0 : ~bw_n_o;
    wait_ph(3'h5);
    // Stray strobe across K_N only, must not start a write
    wr_n_o <= ~bogus;
    rd_n_o <= 1'b1;
    addr_o <= ~addr_o;
    data_o <= dv ? d1 : ~data_o;
    bw_n_o <= dv ? b1 : ~bw_n_o;
  endtask
endmodule

// ---- verif/bsr_top_bench.sv ----
`timescale 1ns/10ps
module bsr_top_bench;
  import bsr_pkg::*;
  typedef struct {bsr_data_t d; int due; logic odd;} bsr_note_s;
  logic CLK_I, RST_I, DOFF_N_I, WIDE36_I, K_I, K_N_I, WR_N_I, RD_N_I;
  logic ECHO_POS_O, ECHO_NEG_O, OUT_VALID_O, READ_OE_O, DLL_LOCKED_O;
  logic [3:0] BYTE_WR_N_I;
  bsr_addr_t ADDRESS_IN_I;
  bsr_data_t WRITE_DATA_IN_I, READ_DATA_OUT_O;
  bsr_data_t shadow [MEM_WORDS];
  bsr_note_s notes [$];
  int hcnt, ecnt, rg, lat;
  int err_count = 0;
  int n_checks = 0;
  int seed = 32'h62A1;
  bsr_top DUT (.CLK_I(CLK_I), .RST_I(RST_I), .K_I(K_I), .K_N_I(K_N_I), .DOFF_N_I(DOFF_N_I),
    .WR_N_I(WR_N_I), .RD_N_I(RD_N_I), .WIDE36_I(WIDE36_I), .ADDRESS_IN_I(ADDRESS_IN_I),
    .WRITE_DATA_IN_I(WRITE_DATA_IN_I), .BYTE_WR_N_I(BYTE_WR_N_I), .ECHO_POS_O(ECHO_POS_O),
    .ECHO_NEG_O(ECHO_NEG_O), .OUT_VALID_O(OUT_VALID_O), .READ_OE_O(READ_OE_O),
    .READ_DATA_OUT_O(READ_DATA_OUT_O), .DLL_LOCKED_O(DLL_LOCKED_O));
  bsr_ctrl_model U_CTRL (.clk_i(CLK_I), .k_o(K_I), .k_n_o(K_N_I), .wr_n_o(WR_N_I),
    .rd_n_o(RD_N_I), .addr_o(ADDRESS_IN_I), .data_o(WRITE_DATA_IN_I), .bw_n_o(BYTE_WR_N_I),
    .hcnt_o(hcnt));
  initial
  begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  task automatic chk_data(input string what, input bsr_data_t exp, input bsr_data_t got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_data(what, bsr_data_t'(exp), bsr_data_t'(got));
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic idle(input int n);
    int ki;
    repeat (n) U_CTRL.kcyc(1'b1, 1'b1, 1'b0, 1'b0, '0, '0, '0, 4'hF, 4'hF, ki);
  endtask
  // Writes on even K cycles, reads of the previous round's words on odd ones
  task automatic rounds(input int nr, input logic bogus);
    bsr_data_t d [2];
    logic [3:0] b [2];
    bsr_addr_t a;
    int ki, w;
    logic wr, rd;
    for (int r = 0; r < nr; r++)
    begin
      for (int c = 0; c < 9; c++)
      begin
        wr = (c % 2 == 0) && (c < 8);
        rd = (c % 2 == 1) && (rg > 0);
        for (int h = 0; h < 2; h++)
        begin
          d[h] = DATA_W'({$random(seed), $random(seed)});
          b[h] = 4'($random(seed));
          // Regions repeat every four rounds, so disabled bytes must keep old data
          w = (rg % 4) * 16 + (c - 1) / 2 * 4 + ((c % 2) ? 0 : 2) + h;
          if (c > 0)
          begin
            if ((^shadow[w]) === 1'bx)
              b[h] = 4'h0;
            for (int k = 0; k < (WIDE36_I ? BYTES : NARROW_BYTES); k++)
              if (!b[h][k])
                shadow[w][BYTE_W*k +: BYTE_W] = d[h][BYTE_W*k +: BYTE_W];
          end
        end
        a = ADDR_W'($random(seed));
        a[5:0] = 6'(wr ? (rg % 4) * 4 + c / 2 : ((rg - 1) % 4) * 4 + c / 2);
        U_CTRL.kcyc(~wr, ~rd, bogus, c > 0, a, d[0], d[1], b[0], b[1], ki);
        if (rd)
          for (int j = 0; j < BEATS; j++)
            notes.push_back('{shadow[a[5:0] * 4 + j] &
              {{(DATA_W-NARROW_W){WIDE36_I}}, {NARROW_W{1'b1}}}, ki + lat + j, j[0]});
      end
      rg++;
    end
    idle(3);
  endtask
  initial
  begin : watch
    logic pp, pn;
    bsr_note_s n;
    pp = 1'b0;
    pn = 1'b0;
    forever
    begin
      @(negedge CLK_I);
      if (!RST_I && (ECHO_POS_O !== pp || ECHO_NEG_O !== pn))
      begin
        ecnt++;
        chk_bit("echo pair", ~ECHO_POS_O, ECHO_NEG_O);
        if (OUT_VALID_O === 1'b1 && notes.size() > 0)
        begin
          n = notes.pop_front();
          chk_data("read beat", n.d, READ_DATA_OUT_O);
          chk_bit("beat time", 1'b1, (hcnt - n.due) inside {0, 1});
          chk_bit("echo phase", n.odd, ECHO_POS_O);
          chk_bit("read drive", 1'b1, READ_OE_O);
        end
        else
        begin
          chk_bit("valid flag", 1'b0, OUT_VALID_O);
          chk_bit("read drive", 1'b0, READ_OE_O);
          chk_data("idle data", '0, READ_DATA_OUT_O);
          chk_bit("beat late", 1'b0, notes.size() > 0 && hcnt > notes[0].due + 1);
        end
      end
      pp = ECHO_POS_O;
      pn = ECHO_NEG_O;
    end
  end
  initial
  begin
    int h0;
    RST_I = 1'b1;
    DOFF_N_I = 1'b1;
    WIDE36_I = 1'b1;
    lat = RD_FIRST_DLL;
    repeat (20) @(negedge CLK_I);
    RST_I = 1'b0;
    h0 = hcnt;
    idle(2);
    chk_bit("lock at start", 1'b0, DLL_LOCKED_O);
    rounds(6, 1'b0);
    $display("test wide burst traffic done");
    while (hcnt - h0 < 2 * (LOCK_KCYCLES - 10))
      idle(1);
    chk_bit("lock early", 1'b0, DLL_LOCKED_O);
    idle(20);
    chk_bit("lock reached", 1'b1, DLL_LOCKED_O);
    DOFF_N_I = 1'b0;
    idle(1);
    chk_bit("lock dropped", 1'b0, DLL_LOCKED_O);
    $display("test lock time done");
    lat = RD_FIRST_BYP;
    rounds(4, 1'b1);
    $display("test bypass and stray strobes done");
    DOFF_N_I = 1'b1;
    WIDE36_I = 1'b0;
    lat = RD_FIRST_DLL;
    idle(2);
    rounds(4, 1'b0);
    $display("test narrow configuration done");
    h0 = ecnt;
    idle(10);
    chk_bit("echo free run", 1'b1, ecnt - h0 >= 19);
    $display("test idle echo done");
    final_report();
  end
  initial
  begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule

// ---- verilog/bsr_pkg.sv ----
package bsr_pkg;
  // Pin widths and burst length
  localparam int ADDR_W   = 18;
  localparam int DATA_W   = 36;
  localparam int NARROW_W = 18;
  localparam int BYTE_W   = 9;
  localparam int BYTES    = 4;
  localparam int NARROW_BYTES = 2;
  localparam int BEATS    = 4;
  // Stored depth in bursts, as address bits taken from the low end of the address
  localparam int MEM_AW   = 6;
  localparam int MEM_WORDS = (1 << MEM_AW) * BEATS;
  // Half-cycle pipeline, counted in input-clock rising edges of either phase
  // Deep enough to hold a DLL-mode read up to its last beat at half-edge 8
  localparam int PIPE_LEN     = 9;
  localparam int RD_FIRST_DLL = 5;
  localparam int RD_FIRST_BYP = 3;
  localparam int WR_FIRST     = 2;
  // Lock time in input-clock cycles
  localparam int LOCK_KCYCLES = 1024;
  localparam int LOCK_W       = 11;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_KCYCLES - 1);
  // Synchronised pin vector layout
  localparam int SY_K    = 0;
  localparam int SY_KN   = 1;
  localparam int SY_DOFF = 2;
  localparam int SY_WR   = 3;
  localparam int SY_RD   = 4;
  localparam int SY_WIDE = 5;
  localparam int SY_BW   = 6;
  localparam int SY_ADDR = SY_BW + BYTES;
  localparam int SY_DATA = SY_ADDR + ADDR_W;
  localparam int SY_W    = SY_DATA + DATA_W;
  typedef logic [ADDR_W-1:0] bsr_addr_t;
  typedef logic [DATA_W-1:0] bsr_data_t;
endpackage

// ---- verilog/bsr_sync.sv ----
`timescale 1ns/10ps
module bsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic q_ff;
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          q_ff  <= 1'b0;
        end
        else
        begin
          s1_ff <= d_i[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          // Level only moves once two settled stages agree
          if (s2_ff == s3_ff)
            q_ff <= s3_ff;
        end
      end
      assign q_o[g] = q_ff;
    end
  endgenerate
endmodule

// ---- verilog/bsr_top.sv ----
// Notes on behaviour
// - Address and commands are sampled only on rising true input clock edges.
// - Write data captured on rising edges of both clocks, two beats per cycle.
// - Echo clocks toggle continuously, even while read data is not driven.
// - Echo clock edges line up with read data transitions.
// - DLL-disable low bypasses the DLL and clears any lock.
// - DLL-disable high runs the DLL, locking after the lock time.
// - DLL off uses shorter read latency; controller keeps clock at 167 MHz or less.
// - Output-valid high while read data is valid, edges aligned to echo clocks.
// - Address is ignored in cycles without a read or write command.
// - Narrow configuration uses lines 0 to 17; wide uses all 36.
// - Read data is timed to the echo clocks, which follow the input clocks.
// - Read data bus driven only in answer to read commands.
// - Write command low at true clock rise registers address, starts a write.
// - Read command low at true clock rise registers address, starts a read.
// - First read beat 2.5 cycles after command with DLL on, 1.5 with DLL off, on complementary edge, three follow.
// - Byte write enables sampled with their beat; low writes, high keeps the byte.
`timescale 1ns/10ps
module bsr_top (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic              K_I,
  input  wire logic              K_N_I,
  input  wire logic              DOFF_N_I,
  input  wire logic              WR_N_I,
  input  wire logic              RD_N_I,
  input  wire logic              WIDE36_I,
  input  wire bsr_pkg::bsr_addr_t ADDRESS_IN_I,
  input  wire bsr_pkg::bsr_data_t WRITE_DATA_IN_I,
  input  wire logic [3:0]        BYTE_WR_N_I,
  output logic                   ECHO_POS_O,
  output logic                   ECHO_NEG_O,
  output logic                   OUT_VALID_O,
  output logic                   READ_OE_O,
  output bsr_pkg::bsr_data_t     READ_DATA_OUT_O,
  output logic                   DLL_LOCKED_O
);
  import bsr_pkg::*;

  logic [SY_W-1:0] sy_d;
  logic [SY_W-1:0] sy_q;
  assign sy_d = {WRITE_DATA_IN_I, ADDRESS_IN_I, BYTE_WR_N_I, WIDE36_I,
                 RD_N_I, WR_N_I, DOFF_N_I, K_N_I, K_I};

  bsr_sync #(.W(SY_W)) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (sy_d),
    .q_o   (sy_q)
  );

  wire             k_lvl    = sy_q[SY_K];
  wire             kn_lvl   = sy_q[SY_KN];
  wire             doff_lvl = sy_q[SY_DOFF];
  wire             wr_n_lvl = sy_q[SY_WR];
  wire             rd_n_lvl = sy_q[SY_RD];
  wire             wide_lvl = sy_q[SY_WIDE];
  wire [BYTES-1:0] bw_n_lvl = sy_q[SY_BW +: BYTES];
  bsr_addr_t       addr_lvl;
  bsr_data_t       wdat_lvl;
  assign addr_lvl = sy_q[SY_ADDR +: ADDR_W];
  assign wdat_lvl = sy_q[SY_DATA +: DATA_W];

  logic k_prev_ff;
  logic kn_prev_ff;
  wire  k_rise    = k_lvl & ~k_prev_ff;
  wire  kn_rise   = kn_lvl & ~kn_prev_ff;
  wire  half_edge = k_rise | kn_rise;

  // Commands exist only at true clock rises; address is unused otherwise
  wire rd_cmd = k_rise & ~rd_n_lvl;
  wire wr_cmd = k_rise & ~wr_n_lvl;

  logic [PIPE_LEN-1:0] rtok_ff;
  logic [PIPE_LEN-1:0] wtok_ff;
  logic [PIPE_LEN-1:0] nxt_rtok;
  logic [PIPE_LEN-1:0] nxt_wtok;
  bsr_addr_t           raddr_ff [PIPE_LEN];
  bsr_addr_t           waddr_ff [PIPE_LEN];
  bsr_addr_t           nxt_raddr [PIPE_LEN];
  bsr_addr_t           nxt_waddr [PIPE_LEN];

  assign nxt_rtok = {rtok_ff[PIPE_LEN-2:0], rd_cmd};
  assign nxt_wtok = {wtok_ff[PIPE_LEN-2:0], wr_cmd};

  // Each token travels one slot per half-cycle edge
  genvar g;
  generate
    for (g = 0; g < PIPE_LEN; g++)
    begin : g_pipe
      if (g == 0)
      begin : g_head
        assign nxt_raddr[g] = addr_lvl;
        assign nxt_waddr[g] = addr_lvl;
      end
      else
      begin : g_body
        assign nxt_raddr[g] = raddr_ff[g-1];
        assign nxt_waddr[g] = waddr_ff[g-1];
      end
      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
        begin
          raddr_ff[g] <= '0;
          waddr_ff[g] <= '0;
        end
        else if (half_edge)
        begin
          raddr_ff[g] <= nxt_raddr[g];
          waddr_ff[g] <= nxt_waddr[g];
        end
      end
    end
  endgenerate

  // Bypass mode moves the first beat one cycle earlier
  wire dll_off  = ~doff_lvl;
  int  rd_first;
  assign rd_first = dll_off ? RD_FIRST_BYP : RD_FIRST_DLL;

  logic       rd_hit;
  logic [1:0] rd_beat;
  bsr_addr_t  rd_addr;
  logic       wr_hit;
  logic [1:0] wr_beat;
  bsr_addr_t  wr_addr;
  always_comb
  begin
    rd_hit  = 1'b0;
    rd_beat = 2'h0;
    rd_addr = '0;
    wr_hit  = 1'b0;
    wr_beat = 2'h0;
    wr_addr = '0;
    for (int j = 0; j < BEATS; j++)
    begin
      if (nxt_rtok[rd_first + j])
      begin
        rd_hit  = 1'b1;
        rd_beat = j[1:0];
        rd_addr = nxt_raddr[rd_first + j];
      end
      if (nxt_wtok[WR_FIRST + j])
      begin
        wr_hit  = 1'b1;
        wr_beat = j[1:0];
        wr_addr = nxt_waddr[WR_FIRST + j];
      end
    end
  end

  bsr_data_t mem [MEM_WORDS];
  wire [MEM_AW+1:0] widx = {wr_addr[MEM_AW-1:0], wr_beat};
  wire [MEM_AW+1:0] ridx = {rd_addr[MEM_AW-1:0], rd_beat};
  wire [BYTES-1:0]  byte_ok = wide_lvl ? {BYTES{1'b1}} : {{(BYTES-NARROW_BYTES){1'b0}},
                                                        {NARROW_BYTES{1'b1}}};
  bsr_data_t rword;
  assign rword = wide_lvl ? mem[ridx] : {{(DATA_W-NARROW_W){1'b0}}, mem[ridx][NARROW_W-1:0]};

  // Memory array has no reset; content is undefined until written
  always_ff @(posedge CLK_I)
  begin
    if (half_edge && wr_hit)
    begin
      for (int b = 0; b < BYTES; b++)
        if (!bw_n_lvl[b] && byte_ok[b])
          mem[widx][b*BYTE_W +: BYTE_W] <= wdat_lvl[b*BYTE_W +: BYTE_W];
    end
  end

  logic              lock_ff;
  logic [LOCK_W-1:0] lock_cnt_ff;
  logic              echo_pos_ff;
  logic              echo_neg_ff;
  logic              oe_ff;
  logic              valid_ff;
  bsr_data_t         rdata_ff;

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      k_prev_ff   <= 1'b0;
      kn_prev_ff  <= 1'b0;
      rtok_ff     <= '0;
      wtok_ff     <= '0;
      echo_pos_ff <= 1'b0;
      echo_neg_ff <= 1'b0;
      oe_ff       <= 1'b0;
      valid_ff    <= 1'b0;
      rdata_ff    <= '0;
    end
    else
    begin
      k_prev_ff   <= k_lvl;
      kn_prev_ff  <= kn_lvl;
      // Free running copies, updated on the same edge as the data
      echo_pos_ff <= k_lvl;
      echo_neg_ff <= kn_lvl;
      if (half_edge)
      begin
        rtok_ff  <= nxt_rtok;
        wtok_ff  <= nxt_wtok;
        oe_ff    <= rd_hit;
        valid_ff <= rd_hit;
        rdata_ff <= rd_hit ? rword : '0;
      end
    end
  end

  // Lock count is in input-clock cycles, so it stalls if the clock stops
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      lock_ff     <= 1'b0;
      lock_cnt_ff <= '0;
    end
    else if (!doff_lvl)
    begin
      lock_ff     <= 1'b0;
      lock_cnt_ff <= '0;
    end
    else if (k_rise && !lock_ff)
    begin
      if (lock_cnt_ff == LOCK_LAST)
        lock_ff <= 1'b1;
      else
        lock_cnt_ff <= lock_cnt_ff + 1'b1;
    end
  end

  assign ECHO_POS_O      = echo_pos_ff;
  assign ECHO_NEG_O      = echo_neg_ff;
  assign OUT_VALID_O     = valid_ff;
  assign READ_OE_O       = oe_ff;
  assign READ_DATA_OUT_O = rdata_ff;
  assign DLL_LOCKED_O    = lock_ff;

  a_oe_needs_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(oe_ff) |-> (|rtok_ff)) else $error("read bus driven without read");
  a_valid_with_oe: assert property (@(posedge CLK_I) disable iff (RST_I)
    valid_ff == oe_ff && (oe_ff || rdata_ff == '0)) else $error("valid not tied to data");
  a_echo_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
    k_rise |=> echo_pos_ff ##4 1'b1) else $error("echo clock did not follow");
  a_dll_bypass: assert property (@(posedge CLK_I) disable iff (RST_I)
    !doff_lvl |=> !lock_ff && lock_cnt_ff == '0) else $error("lock not cleared");
  a_lock_time: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(lock_ff) |-> $past(lock_cnt_ff) == LOCK_LAST) else $error("early lock");
  a_write_take: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_cmd |=> wtok_ff[0] && waddr_ff[0] == $past(addr_lvl)) else $error("write lost");
  a_read_take: assert property (@(posedge CLK_I) disable iff (RST_I)
    rd_cmd |=> rtok_ff[0] && raddr_ff[0] == $past(addr_lvl)) else $error("read lost");
  a_first_beat: assert property (@(posedge CLK_I) disable iff (RST_I)
    half_edge && rtok_ff[RD_FIRST_DLL-1] && doff_lvl |=> oe_ff && !echo_pos_ff)
    else $error("first beat late");
  a_bypass_beat: assert property (@(posedge CLK_I) disable iff (RST_I)
    half_edge && rtok_ff[RD_FIRST_BYP-1] && !doff_lvl |=> oe_ff)
    else $error("bypass beat late");
  a_narrow_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    !wide_lvl && $past(!wide_lvl) |-> rdata_ff[DATA_W-1:NARROW_W] == '0)
    else $error("upper lines used in narrow mode");
endmodule
